/* File: common/lpm_pkg.sv */
// shared constants for the low-power mode controller
package lpm_pkg;
    typedef enum logic [1:0] {
        ST_RUN,
        ST_WAIT,
        ST_STOP,
        ST_RECOVER
    } lp_state_t;

    localparam logic [15:0] VEC_RESET    = 16'hfffe;
    localparam logic [15:0] VEC_BREAK    = 16'hfffc;
    localparam logic [15:0] VEC_PIN_IRQ  = 16'hfffa;
    localparam logic [15:0] VEC_SYNTH    = 16'hfff8;
    localparam logic [15:0] VEC_KEYPAD   = 16'hffde;
    localparam logic [15:0] VEC_TIMEBASE = 16'hffdc;

    localparam int          RECOVER_LONG_CYC  = 4096;
    localparam int          RECOVER_SHORT_CYC = 32;
    localparam int          RECOVER_W         = 12;
    localparam logic [11:0] RECOVER_LONG_LOAD  = 12'(RECOVER_LONG_CYC - 1);
    localparam logic [11:0] RECOVER_SHORT_LOAD = 12'(RECOVER_SHORT_CYC - 1);
    localparam logic [11:0] RECOVER_RESET = 12'h000;
    localparam logic        BCS_RESET     = 1'b0;
endpackage

/* File: hdl/low_power_mode_control.sv */
// wait/stop low-power mode controller: clock gating, wake decode, exit vector
`timescale 1ns/100ps
`default_nettype none

module low_power_mode_control
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    input  wire logic        wait_exec,
    input  wire logic        stop_exec,
    input  wire logic        stop_enable,
    input  wire logic        osc_run_in_stop_enable,
    input  wire logic        short_recovery_select,
    input  wire logic        bcs_write,
    input  wire logic        bcs_wdata,
    input  wire logic        pin_reset_b,
    input  wire logic        watchdog_timeout,
    input  wire logic        lvm_enable,
    input  wire logic        lvm_reset_enable,
    input  wire logic        lvm_low,
    input  wire logic        irq_pin_b,
    input  wire logic        pin_interrupt_mask,
    input  wire logic        keypad_req,
    input  wire logic        keypad_interrupt_mask,
    input  wire logic        break_req,
    input  wire logic        synth_irq,
    input  wire logic        timebase_irq,
    input  wire logic        periph_irq,
    input  wire logic [15:0] periph_vector,
    output lpm_pkg::lp_state_t lp_state,
    output logic             cpu_clock_en,
    output logic             bus_clock_en,
    output logic             osc_enable,
    output logic             synth_power_on,
    output logic             crystal_clock_en,
    output logic             generator_output_clock_en,
    output logic             generator_int_clock_en,
    output logic             base_clock_select,
    output logic             watchdog_clock_en,
    output logic             watchdog_prescaler_clear,
    output logic             breakpoint_unit_idle,
    output logic             serial_clock_en,
    output logic             timer_clock_en,
    output logic             timebase_clock_en,
    output logic             timebase_access_en,
    output logic             imask_clear,
    output logic             imask_set,
    output logic             break_during_wait_flag_set,
    output logic             sync_serial_abort,
    output logic             illegal_opcode_reset,
    output logic             vector_valid,
    output logic [15:0]      vector_addr
);
    import lpm_pkg::*;

    lp_state_t        state_q, state_d;
    logic [11:0]      recov_q, recov_d;
    logic             bcs_q;
    logic [1:0]       irq_sync_q;
    logic             irq_last_q;
    logic [1:0]       rst_sync_q;
    logic             imask_clear_q, imask_set_q, bw_set_q, abort_q, ilop_q;
    logic             vec_valid_q;
    logic [15:0]      vec_q;

    // pins pass two flops before any logic reads them
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_sync_q <= 2'b11;
            irq_last_q <= 1'b1;
            rst_sync_q <= 2'b11;
        end else if (clk_en) begin
            irq_sync_q <= {irq_sync_q[0], irq_pin_b};
            irq_last_q <= irq_sync_q[1];
            rst_sync_q <= {rst_sync_q[0], pin_reset_b};
        end
    end

    wire in_run     = (state_q == ST_RUN);
    wire in_wait    = (state_q == ST_WAIT);
    wire in_stop    = (state_q == ST_STOP);
    wire in_recover = (state_q == ST_RECOVER);
    wire low_power  = in_wait | in_stop;

    // wake and reset sources
    wire irq_fall   = irq_last_q & ~irq_sync_q[1];
    wire irq_wake   = irq_fall & ~pin_interrupt_mask;
    wire kbd_wake   = keypad_req & ~keypad_interrupt_mask;
    wire lvm_rst    = lvm_enable & lvm_reset_enable & lvm_low;
    wire pin_rst    = ~rst_sync_q[1];
    // watchdog has no clock in stop, so its timeout only matters in wait
    wire wait_rst   = pin_rst | lvm_rst | watchdog_timeout;
    wire stop_rst   = pin_rst | lvm_rst;
    wire tb_stop_ok = timebase_irq & osc_run_in_stop_enable;

    wire wait_exit  = wait_rst | break_req | irq_wake | synth_irq
                    | kbd_wake | timebase_irq | periph_irq;
    wire stop_exit  = stop_rst | break_req | irq_wake | kbd_wake | tb_stop_ok;

    // exit vector, highest priority first
    wire [15:0] wait_vec = wait_rst     ? VEC_RESET    :
                           break_req    ? VEC_BREAK    :
                           irq_wake     ? VEC_PIN_IRQ  :
                           synth_irq    ? VEC_SYNTH    :
                           kbd_wake     ? VEC_KEYPAD   :
                           timebase_irq ? VEC_TIMEBASE :
                                          periph_vector;
    wire [15:0] stop_vec = stop_rst     ? VEC_RESET    :
                           break_req    ? VEC_BREAK    :
                           irq_wake     ? VEC_PIN_IRQ  :
                           kbd_wake     ? VEC_KEYPAD   :
                                          VEC_TIMEBASE;

    wire go_wait    = in_run & wait_exec;
    wire go_stop    = in_run & stop_exec & stop_enable;
    wire bad_stop   = in_run & stop_exec & ~stop_enable;
    wire leave_wait = in_wait & wait_exit;
    wire leave_stop = in_stop & stop_exit;
    wire recov_done = in_recover & (recov_q == RECOVER_RESET);
    wire [11:0] recov_load = short_recovery_select ? RECOVER_SHORT_LOAD
                                                   : RECOVER_LONG_LOAD;

    always_comb begin
        state_d = state_q;
        recov_d = recov_q;
        case (state_q)
            ST_RUN: begin
                if (go_wait) begin
                    state_d = ST_WAIT;
                end else if (go_stop) begin
                    state_d = ST_STOP;
                end
            end
            ST_WAIT: begin
                if (wait_exit) begin
                    state_d = ST_RUN;
                end
            end
            ST_STOP: begin
                if (stop_exit) begin
                    state_d = ST_RECOVER;
                    recov_d = recov_load;
                end
            end
            ST_RECOVER: begin
                if (recov_q == RECOVER_RESET) begin
                    state_d = ST_RUN;
                end else begin
                    recov_d = recov_q - 12'h001;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_RUN;
            recov_q <= RECOVER_RESET;
        end else if (clk_en) begin
            state_q <= state_d;
            recov_q <= recov_d;
        end
    end

    // base clock select: stop entry forces the halved crystal clock and
    // the hardware clear wins over a same-cycle software write
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bcs_q <= BCS_RESET;
        end else if (clk_en) begin
            if (go_stop) begin
                bcs_q <= 1'b0;
            end else if (bcs_write & in_run) begin
                bcs_q <= bcs_wdata;
            end
        end
    end

    // event pulses to core and peripherals
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            imask_clear_q <= 1'b0;
            imask_set_q   <= 1'b0;
            bw_set_q      <= 1'b0;
            abort_q       <= 1'b0;
            ilop_q        <= 1'b0;
            vec_valid_q   <= 1'b0;
            vec_q         <= VEC_RESET;
        end else if (clk_en) begin
            imask_clear_q <= go_wait | go_stop;
            imask_set_q   <= (leave_wait & wait_rst) | (leave_stop & stop_rst);
            bw_set_q      <= leave_stop & ~stop_rst & break_req;
            abort_q       <= leave_stop & stop_rst;
            ilop_q        <= bad_stop;
            vec_valid_q   <= leave_wait | recov_done;
            if (leave_wait) begin
                vec_q <= wait_vec;
            end else if (leave_stop) begin
                vec_q <= stop_vec;
            end
        end
    end

    // clock and module gating
    wire osc_off_stop = (in_stop | in_recover) & ~osc_run_in_stop_enable;
    assign lp_state                  = state_q;
    assign cpu_clock_en              = in_run;
    assign bus_clock_en              = in_run | in_wait
                                     | (in_stop & osc_run_in_stop_enable);
    assign osc_enable                = ~(in_stop & ~osc_run_in_stop_enable);
    assign synth_power_on            = ~(in_stop | in_recover);
    assign crystal_clock_en          = ~(in_stop & ~osc_run_in_stop_enable);
    assign generator_output_clock_en = ~osc_off_stop;
    assign generator_int_clock_en    = ~osc_off_stop;
    assign base_clock_select         = bcs_q;
    assign watchdog_clock_en         = ~(in_stop | in_recover);
    assign watchdog_prescaler_clear  = in_stop;
    assign breakpoint_unit_idle      = in_stop;
    // serial and timer state is frozen, not reset, so it resumes on exit
    assign serial_clock_en           = ~(in_stop | in_recover);
    assign timer_clock_en            = ~(in_stop | in_recover);
    assign timebase_clock_en         = in_run | in_wait
                                     | (in_stop & osc_run_in_stop_enable);
    assign timebase_access_en        = ~low_power;
    assign imask_clear               = imask_clear_q;
    assign imask_set                 = imask_set_q;
    assign break_during_wait_flag_set = bw_set_q;
    assign sync_serial_abort         = abort_q;
    assign illegal_opcode_reset      = ilop_q;
    assign vector_valid              = vec_valid_q;
    assign vector_addr               = vec_q;

    a_wait_entry: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && go_wait) |=> (state_q == ST_WAIT) && imask_clear && !cpu_clock_en)
        else $error("wait entry did not gate cpu clock or clear mask");

    a_stop_entry: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && go_stop) |=> in_stop && imask_clear && !cpu_clock_en)
        else $error("stop entry did not gate cpu clock or clear mask");

    a_stop_disabled: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && bad_stop) |=> illegal_opcode_reset && in_run)
        else $error("disabled stop did not raise illegal opcode reset");

    a_short_recov: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && leave_stop && short_recovery_select)
        |=> (recov_q == RECOVER_SHORT_LOAD) && !cpu_clock_en)
        else $error("short recovery not loaded");

    a_recov_hold: assert property (@(posedge clk) disable iff (!rst_b)
        in_recover |-> !cpu_clock_en && !bus_clock_en)
        else $error("clocks running during recovery");

    a_bcs_cleared: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && go_stop) |=> !base_clock_select)
        else $error("stop entry left base clock select set");

    a_wait_bus: assert property (@(posedge clk) disable iff (!rst_b)
        in_wait |-> bus_clock_en && timebase_clock_en && watchdog_clock_en
                    && !timebase_access_en)
        else $error("wait mode gating wrong");

    a_osc_off: assert property (@(posedge clk) disable iff (!rst_b)
        (in_stop && !osc_run_in_stop_enable)
        |-> !osc_enable && !crystal_clock_en && !generator_output_clock_en
            && !synth_power_on && !timebase_clock_en)
        else $error("oscillator not shut down in stop");

    a_masked_irq: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && in_stop && pin_interrupt_mask && !stop_rst && !break_req
         && !kbd_wake && !tb_stop_ok) |=> in_stop)
        else $error("masked source woke stop");

    a_reset_vec: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && leave_wait && wait_rst)
        |=> vector_valid && vector_addr == VEC_RESET && imask_set)
        else $error("reset wait exit vector wrong");

    a_spi_abort: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && leave_stop && stop_rst) |=> sync_serial_abort)
        else $error("reset stop exit did not abort sync serial");
endmodule

`default_nettype wire

/* File: sim/core_model.sv */
// behavioural core: interrupt mask and program counter as the cpu sees them
`timescale 1ns/100ps
`default_nettype none
module core_model (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        imask_clear,
    input  wire logic        imask_set,
    input  wire logic        vector_valid,
    input  wire logic [15:0] vector_addr,
    output logic             i_mask,
    output logic [15:0]      pc
);
    // set wins: a reset exit must leave interrupts masked
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            i_mask <= 1'b1;
            pc     <= 16'hfffe;
        end else begin
            if (imask_set) begin
                i_mask <= 1'b1;
            end else if (imask_clear) begin
                i_mask <= 1'b0;
            end
            if (vector_valid) begin
                pc <= vector_addr;
            end
        end
    end
endmodule
`default_nettype wire

/* File: sim/low_power_mode_control_tb.sv */
// self-checking bench for the low-power mode controller
`timescale 1ns/100ps
`default_nettype none
module low_power_mode_control_tb;
    import lpm_pkg::*;
    logic      clk, rst_b, clk_en, wait_exec, stop_exec, stop_enable, bcs_write, bcs_wdata;
    logic      osc_run_in_stop_enable, short_recovery_select, lvm_enable, lvm_reset_enable;
    logic      pin_interrupt_mask, keypad_interrupt_mask, i_mask;
    logic      cpu_clock_en, bus_clock_en, osc_enable, synth_power_on, crystal_clock_en;
    logic      generator_output_clock_en, generator_int_clock_en, base_clock_select;
    logic      watchdog_clock_en, watchdog_prescaler_clear, breakpoint_unit_idle;
    logic      serial_clock_en, timer_clock_en, timebase_clock_en, timebase_access_en;
    logic      imask_clear, imask_set, break_during_wait_flag_set, sync_serial_abort;
    logic      illegal_opcode_reset, vector_valid, seen_bdw, seen_abort;
    logic [8:0]  src;
    logic [15:0] periph_vector, vector_addr, pc;
    lp_state_t   lp_state;
    int          err_total, n_compared, seed, rec;
    logic [15:0] pv_tab [10] = '{16'hfff2, 16'hfff4, 16'hfff6, 16'hffec, 16'hfff0,
                                 16'hffe8, 16'hffea, 16'hffe2, 16'hffe4, 16'hffe6};
    int          s_src [6] = '{3, 7, 2, 6, 4, 0};
    logic        s_osc [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    logic        s_ssr [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

    // source index: 0 pin reset, 1 watchdog, 2 voltage, 3 break, 4 pin irq,
    // 5 synth, 6 keypad, 7 timebase, 8 timer/serial
    low_power_mode_control low_power_mode_control_inst (
        .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .wait_exec(wait_exec),
        .stop_exec(stop_exec), .stop_enable(stop_enable),
        .osc_run_in_stop_enable(osc_run_in_stop_enable),
        .short_recovery_select(short_recovery_select),
        .bcs_write(bcs_write), .bcs_wdata(bcs_wdata),
        .pin_reset_b(!src[0]), .watchdog_timeout(src[1]), .lvm_enable(lvm_enable),
        .lvm_reset_enable(lvm_reset_enable), .lvm_low(src[2]), .irq_pin_b(!src[4]),
        .pin_interrupt_mask(pin_interrupt_mask), .keypad_req(src[6]),
        .keypad_interrupt_mask(keypad_interrupt_mask), .break_req(src[3]),
        .synth_irq(src[5]), .timebase_irq(src[7]), .periph_irq(src[8]),
        .periph_vector(periph_vector), .lp_state(lp_state), .cpu_clock_en(cpu_clock_en),
        .bus_clock_en(bus_clock_en), .osc_enable(osc_enable),
        .synth_power_on(synth_power_on), .crystal_clock_en(crystal_clock_en),
        .generator_output_clock_en(generator_output_clock_en),
        .generator_int_clock_en(generator_int_clock_en),
        .base_clock_select(base_clock_select), .watchdog_clock_en(watchdog_clock_en),
        .watchdog_prescaler_clear(watchdog_prescaler_clear),
        .breakpoint_unit_idle(breakpoint_unit_idle), .serial_clock_en(serial_clock_en),
        .timer_clock_en(timer_clock_en), .timebase_clock_en(timebase_clock_en),
        .timebase_access_en(timebase_access_en), .imask_clear(imask_clear),
        .imask_set(imask_set), .break_during_wait_flag_set(break_during_wait_flag_set),
        .sync_serial_abort(sync_serial_abort), .illegal_opcode_reset(illegal_opcode_reset),
        .vector_valid(vector_valid), .vector_addr(vector_addr));

    core_model core_model_inst (
        .clk(clk), .rst_b(rst_b), .imask_clear(imask_clear), .imask_set(imask_set),
        .vector_valid(vector_valid), .vector_addr(vector_addr), .i_mask(i_mask), .pc(pc));

    initial begin
        clk = 1'b0;
        forever #50 clk = !clk;
    end

    task automatic report(input logic [15:0] exp, input logic [15:0] got);
        err_total++;
        $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    endtask

    task automatic chk_bit(input logic exp, input logic got);
        n_compared++;
        if (got !== exp) report(16'(exp), 16'(got));
    endtask

    task automatic chk_vec(input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) report(exp, got);
    endtask

    task automatic chk_state(input lp_state_t exp, input lp_state_t got);
        n_compared++;
        if (got !== exp) report(16'(exp), 16'(got));
    endtask

    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    function automatic logic [15:0] exp_vec(input int i);
        case (i)
            0, 1, 2: return VEC_RESET;
            3: return VEC_BREAK;
            4: return VEC_PIN_IRQ;
            5: return VEC_SYNTH;
            6: return VEC_KEYPAD;
            7: return VEC_TIMEBASE;
            default: return periph_vector;
        endcase
    endfunction

    task automatic fire(input int i);
        @(posedge clk);
        src[i] <= 1'b1;
        @(posedge clk);
        src[i] <= 1'b0;
    endtask

    task automatic enter(input logic stp);
        @(posedge clk);
        wait_exec <= !stp;
        stop_exec <= stp;
        @(posedge clk);
        wait_exec <= 1'b0;
        stop_exec <= 1'b0;
        #1;
        chk_state(stp ? ST_STOP : ST_WAIT, lp_state);
        chk_bit(1'b1, imask_clear);
        chk_bit(1'b0, cpu_clock_en);
    endtask

    // counts recovery cycles and catches one-cycle side pulses until the vector
    task automatic leave(input int i);
        rec = 0;
        seen_bdw = 1'b0;
        seen_abort = 1'b0;
        #1;
        for (int k = 0; k < 6000; k++) begin
            if (lp_state === ST_RECOVER) rec++;
            seen_bdw |= break_during_wait_flag_set;
            seen_abort |= sync_serial_abort;
            if (vector_valid === 1'b1) break;
            @(posedge clk);
            #1;
        end
        chk_bit(1'b1, vector_valid);
        chk_vec(exp_vec(i), vector_addr);
        repeat (2) @(posedge clk);
        #1;
        chk_bit(i < 3, i_mask);
        chk_vec(exp_vec(i), pc);
    endtask

    initial begin
        {rst_b, wait_exec, stop_exec, bcs_write, bcs_wdata, src, periph_vector} = '0;
        {osc_run_in_stop_enable, short_recovery_select} = '0;
        {pin_interrupt_mask, keypad_interrupt_mask, err_total, n_compared} = '0;
        {clk_en, stop_enable, lvm_enable, lvm_reset_enable} = '1;
        seed = 4408;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk_state(ST_RUN, lp_state);
        chk_bit(1'b1, cpu_clock_en & bus_clock_en);
        chk_bit(1'b0, base_clock_select);
        chk_vec(VEC_RESET, vector_addr);
        for (int r = 0; r < 3; r++) begin
            for (int i = 0; i < 9; i++) begin
                @(posedge clk);
                periph_vector <= pv_tab[$unsigned($random(seed)) % 10];
                enter(1'b0);
                chk_bit(1'b1, bus_clock_en & watchdog_clock_en);
                chk_bit(1'b1, serial_clock_en & timer_clock_en);
                chk_bit(1'b1, timebase_clock_en);
                chk_bit(1'b0, timebase_access_en);
                fire(i);
                leave(i);
                $display("wait exit by source %0d done", i);
            end
        end
        for (int j = 0; j < 6; j++) begin
            @(posedge clk);
            osc_run_in_stop_enable <= s_osc[j];
            short_recovery_select <= s_ssr[j];
            bcs_write <= 1'b1;
            bcs_wdata <= 1'b1;
            @(posedge clk);
            bcs_write <= 1'b0;
            #1;
            chk_bit(1'b1, base_clock_select);
            enter(1'b1);
            chk_bit(1'b0, base_clock_select);
            chk_bit(s_osc[j], osc_enable & crystal_clock_en);
            chk_bit(s_osc[j], generator_output_clock_en);
            chk_bit(s_osc[j], generator_int_clock_en);
            chk_bit(1'b0, synth_power_on);
            chk_bit(s_osc[j], bus_clock_en);
            chk_bit(s_osc[j], timebase_clock_en);
            chk_bit(1'b0, watchdog_clock_en | serial_clock_en | timer_clock_en);
            chk_bit(1'b0, timebase_access_en);
            chk_bit(1'b1, watchdog_prescaler_clear & breakpoint_unit_idle);
            // sources that must not end stop: masked pins, watchdog, synth, timer/serial, timebase with oscillator off
            @(posedge clk);
            pin_interrupt_mask <= 1'b1;
            keypad_interrupt_mask <= 1'b1;
            fire(1);
            fire(5);
            fire(8);
            fire(4);
            fire(6);
            if (!s_osc[j]) fire(7);
            repeat (4) @(posedge clk);
            pin_interrupt_mask <= 1'b0;
            keypad_interrupt_mask <= 1'b0;
            #1;
            chk_state(ST_STOP, lp_state);
            fire(s_src[j]);
            leave(s_src[j]);
            chk_vec(s_ssr[j] ? 16'd32 : 16'd4096, 16'(rec));
            chk_bit(s_src[j] == 3, seen_bdw);
            chk_bit(s_src[j] < 3, seen_abort);
            chk_bit(1'b0, base_clock_select);
            $display("stop exit case %0d done", j);
        end
        @(posedge clk);
        stop_enable <= 1'b0;
        stop_exec <= 1'b1;
        @(posedge clk);
        stop_exec <= 1'b0;
        #1;
        chk_bit(1'b1, illegal_opcode_reset);
        chk_state(ST_RUN, lp_state);
        $display("disabled stop test done");
        // a wait request seen only while the enable is low must be ignored
        @(posedge clk);
        clk_en <= 1'b0;
        wait_exec <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        wait_exec <= 1'b0;
        clk_en <= 1'b1;
        @(posedge clk);
        #1;
        chk_state(ST_RUN, lp_state);
        chk_bit(1'b1, cpu_clock_en);
        $display("clock enable freeze test done");
        summarize();
    end

    // longest path is one long recovery plus five short recoveries and 27 wait exits
    initial begin
        #3000000;
        err_total++;
        summarize();
    end
endmodule
`default_nettype wire
